// ### pkg/axis_consts.svh
// register offsets, field positions, reset values and timing counts of the axis interface
// assumes a 25 MHz system clock and 32-bit APB byte addressing
`ifndef AXIS_CONSTS_SVH
`define AXIS_CONSTS_SVH

`define ADDR_CTRL      8'h00
`define ADDR_POS       8'h04
`define ADDR_LATCH     8'h08
`define ADDR_CMP       8'h0c
`define ADDR_DAC       8'h10
`define ADDR_STEP      8'h14
`define ADDR_IRQ_STAT  8'h18
`define ADDR_IRQ_MASK  8'h1c
`define ADDR_INPUTS    8'h20

`define CTRL_STEPPER   0
`define CTRL_PULSEDIR  1
`define CTRL_SCALE_LO  2
`define CTRL_SCALE_HI  3
`define CTRL_LATCH_IDX 4
`define CTRL_LATCH_ARM 5
`define CTRL_IDX_ZERO  6
`define CTRL_AUX_IN    7
`define CTRL_RESET     8'h00

`define IRQ_LATCH      0
`define IRQ_CMP        1
`define IRQ_INDEX      2
`define IRQ_STEP       3

`define SCALE_FULL     2'h0
`define SCALE_HALF     2'h1
`define SHIFT_HALF     5'h01
`define SHIFT_MICRO    5'h04

`define CLK_NS         40
`define STEP_HIGH_NS   80
`define STEP_HALF_CYC  ((`STEP_HIGH_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ### pkg/axis_pkg.sv
// types shared by the axis encoder and step interface
// assumes axis_consts.svh for all numeric constants
package axis_pkg;

  typedef enum logic [1:0] {STEP_IDLE, STEP_HIGH, STEP_LOW} step_e;

  typedef struct packed {
    logic [1:0]  sA;
    logic [1:0]  sB;
    logic [1:0]  sI;
    logic [1:0]  sG;
    logic [1:0]  sX0;
    logic [1:0]  sX1;
    logic        qA;
    logic        qB;
    logic        qI;
    logic        qG;
    logic [31:0] pos;
    logic [31:0] latch;
    logic [31:0] cmp;
    logic [15:0] dac;
    logic [7:0]  ctrl;
    logic [19:0] stepLeft;
    step_e       stepSt;
    logic [3:0]  stepCnt;
    logic [3:0]  irqStat;
    logic [3:0]  irqMask;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irq;
    logic        cmpOut;
    logic        stepOut;
    logic        dirOut;
    logic [15:0] dacOut;
  } state_s;

endpackage

// ### core/axis_encoder_step_interface.sv
// one motion axis: encoder decoding, index sync, latch, compare, servo code and step output
// assumes asynchronous encoder and latch pins, a 25 MHz clk, synchronous active-high rst and an APB master
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "axis_consts.svh"
`default_nettype none

module axis_encoder_step_interface (
  input  wire logic        clk,            // system clock
  input  wire logic        rst,            // synchronous reset
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb enable
  input  wire logic        pwrite,         // apb direction
  input  wire logic [7:0]  paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic             pready,         // apb ready
  output logic [31:0]      prdata,         // apb read data
  output logic             pslverr,        // apb error
  input  wire logic        quadChannelA,   // encoder channel a or pulse
  input  wire logic        quadChannelB,   // encoder channel b or direction
  input  wire logic        encIndex,       // encoder index
  input  wire logic        genInput,       // general latch input
  input  wire logic [1:0]  auxLines,       // auxiliary encoder lines
  output logic             cmpOut,         // compare output
  output logic             stepOut,        // step pulse
  output logic             dirOut,         // step direction
  output logic [15:0]      dacCode,        // servo converter code
  output logic             irq             // interrupt level
);

  axis_pkg::state_s st;
  axis_pkg::state_s nx;

  logic       stepper;
  logic       pulseDir;
  logic       qChg;
  logic       qUp;
  logic       pdRise;
  logic       idxRise;
  logic       genRise;
  logic       latchEv;
  logic       posWr;
  logic       apbDo;
  logic       rdOk;
  logic [31:0] rdVal;
  logic [4:0] shift;
  logic [19:0] stepMag;
  logic [3:0] irqSet;

  // one state change of the channel pair: valid when exactly one line moved
  function automatic logic quadValid(input logic oa, ob, na, nb);
    quadValid = (oa ^ na) ^ (ob ^ nb);
  endfunction

  function automatic logic [4:0] scaleShift(input logic [1:0] sc);
    unique case (sc)
      `SCALE_FULL: scaleShift = 5'h00;
      `SCALE_HALF: scaleShift = `SHIFT_HALF;
      default:     scaleShift = `SHIFT_MICRO;
    endcase
  endfunction

  always_comb begin
    stepper  = st.ctrl[`CTRL_STEPPER];
    pulseDir = st.ctrl[`CTRL_PULSEDIR];
    qChg     = quadValid(st.qA, st.qB, st.sA[1], st.sB[1]);
    qUp      = (st.qA == st.sB[1]);
    pdRise   = st.sA[1] & ~st.qA;
    idxRise  = st.sI[1] & ~st.qI;
    genRise  = st.sG[1] & ~st.qG;
    latchEv  = st.ctrl[`CTRL_LATCH_ARM] &
               (st.ctrl[`CTRL_LATCH_IDX] ? idxRise : genRise);
    apbDo    = psel & penable & st.pready;
    posWr    = apbDo & pwrite & (paddr == `ADDR_POS);
    shift    = scaleShift(st.ctrl[`CTRL_SCALE_HI:`CTRL_SCALE_LO]);
    stepMag  = pwdata[15] ? 20'(-{{4{pwdata[15]}}, pwdata[15:0]}) : {4'h0, pwdata[15:0]};
    stepMag  = 20'(stepMag << shift);
    rdOk     = 1'b1;
    unique case (paddr)
      `ADDR_CTRL:     rdVal = {24'h000000, st.ctrl};
      `ADDR_POS:      rdVal = st.pos;
      `ADDR_LATCH:    rdVal = st.latch;
      `ADDR_CMP:      rdVal = st.cmp;
      `ADDR_DAC:      rdVal = {16'h0000, st.dac};
      `ADDR_STEP:     rdVal = {12'h000, st.stepLeft};
      `ADDR_IRQ_STAT: rdVal = {28'h0000000, st.irqStat};
      `ADDR_IRQ_MASK: rdVal = {28'h0000000, st.irqMask};
      `ADDR_INPUTS:   rdVal = {28'h0000000,
                               st.ctrl[`CTRL_AUX_IN] ? {st.sX1[1], st.sX0[1]} : 2'h0,
                               st.sI[1], st.sG[1]};
      default: begin
        rdVal = 32'h00000000;
        rdOk  = 1'b0;
      end
    endcase

    nx = st;
    irqSet = 4'h0;

    // position counting, one decoder per axis instance
    if (!pulseDir) begin
      if (qChg) begin
        nx.pos = qUp ? st.pos + 32'h00000001 : st.pos - 32'h00000001;
      end
    end else if (pdRise) begin
      nx.pos = st.sB[1] ? st.pos + 32'h00000001 : st.pos - 32'h00000001;
    end
    if (idxRise) begin
      irqSet[`IRQ_INDEX] = 1'b1;
      if (st.ctrl[`CTRL_IDX_ZERO]) begin
        nx.pos = 32'h00000000;
      end
    end

    if (latchEv) begin
      nx.latch = st.pos;
      irqSet[`IRQ_LATCH] = 1'b1;
    end
    if ((st.pos == st.cmp) && !st.cmpOut) begin
      irqSet[`IRQ_CMP] = 1'b1;
    end
    nx.cmpOut = (st.pos == st.cmp);

    // step pulse generator, high and low halves of equal length
    unique case (st.stepSt)
      axis_pkg::STEP_IDLE: begin
        if (stepper && (st.stepLeft != 20'h00000)) begin
          nx.stepSt  = axis_pkg::STEP_HIGH;
          nx.stepOut = 1'b1;
          nx.stepCnt = 4'(`STEP_HALF_CYC - 1);
        end
      end
      axis_pkg::STEP_HIGH: begin
        if (st.stepCnt != 4'h0) begin
          nx.stepCnt = st.stepCnt - 4'h1;
        end else begin
          nx.stepSt  = axis_pkg::STEP_LOW;
          nx.stepOut = 1'b0;
          nx.stepCnt = 4'(`STEP_HALF_CYC - 1);
        end
      end
      axis_pkg::STEP_LOW: begin
        if (st.stepCnt != 4'h0) begin
          nx.stepCnt = st.stepCnt - 4'h1;
        end else begin
          nx.stepLeft = st.stepLeft - 20'h00001;
          if (st.stepLeft == 20'h00001) begin
            nx.stepSt = axis_pkg::STEP_IDLE;
            irqSet[`IRQ_STEP] = 1'b1;
          end else begin
            nx.stepSt  = axis_pkg::STEP_HIGH;
            nx.stepOut = 1'b1;
            nx.stepCnt = 4'(`STEP_HALF_CYC - 1);
          end
        end
      end
    endcase
    if (!stepper) begin
      nx.stepSt   = axis_pkg::STEP_IDLE;
      nx.stepOut  = 1'b0;
      nx.stepLeft = 20'h00000;
    end

    // apb slave: one wait cycle, then the access completes
    nx.pready = psel & penable & ~st.pready;
    if (psel & penable & ~st.pready) begin
      nx.prdata  = pwrite ? 32'h00000000 : rdVal;
      nx.pslverr = ~rdOk;
    end
    if (apbDo && pwrite) begin
      unique case (paddr)
        `ADDR_CTRL: nx.ctrl = pwdata[7:0];
        `ADDR_POS:  nx.pos  = pwdata;
        `ADDR_CMP:  nx.cmp  = pwdata;
        `ADDR_DAC:  nx.dac  = pwdata[15:0];
        `ADDR_STEP: begin
          // a new move is refused while a move is still pending
          if (stepper && (st.stepLeft == 20'h00000)) begin
            nx.stepLeft = stepMag;
            nx.dirOut   = ~pwdata[15];
          end
        end
        `ADDR_IRQ_STAT: nx.irqStat = st.irqStat & ~pwdata[3:0];
        `ADDR_IRQ_MASK: nx.irqMask = pwdata[3:0];
        default: ;
      endcase
    end
    // hardware clears the arm bit on capture, winning over a software write
    if (latchEv) begin
      nx.ctrl[`CTRL_LATCH_ARM] = 1'b0;
    end
    nx.irqStat = nx.irqStat | irqSet;
    nx.irq     = |(nx.irqStat & nx.irqMask);
    nx.dacOut  = nx.ctrl[`CTRL_STEPPER] ? 16'h0000 : nx.dac;

    if (rst) begin
      nx          = '0;
      nx.ctrl     = `CTRL_RESET;
      nx.stepSt   = axis_pkg::STEP_IDLE;
    end

    // synchronizers and edge stage track the pins through reset: no false edge after it
    nx.sA  = {st.sA[0], quadChannelA};
    nx.sB  = {st.sB[0], quadChannelB};
    nx.sI  = {st.sI[0], encIndex};
    nx.sG  = {st.sG[0], genInput};
    nx.sX0 = {st.sX0[0], auxLines[0]};
    nx.sX1 = {st.sX1[0], auxLines[1]};
    nx.qA  = st.sA[1];
    nx.qB  = st.sB[1];
    nx.qI  = st.sI[1];
    nx.qG  = st.sG[1];
  end

  always_ff @(posedge clk) begin
    st <= nx;
  end

  assign pready  = st.pready;
  assign prdata  = st.prdata;
  assign pslverr = st.pslverr;
  assign cmpOut  = st.cmpOut;
  assign stepOut = st.stepOut;
  assign dirOut  = st.dirOut;
  assign dacCode = st.dacOut;
  assign irq     = st.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_quad_count_up: assert property (
    (!pulseDir && qChg && qUp && !idxRise && !posWr) |=> st.pos == $past(st.pos) + 32'h1)
    else $error("quadrature up step not counted");
  chk_quad_count_down: assert property (
    (!pulseDir && qChg && !qUp && !idxRise && !posWr) |=> st.pos == $past(st.pos) - 32'h1)
    else $error("quadrature down step not counted");
  chk_pulse_dir_count: assert property (
    (pulseDir && pdRise && st.sB[1] && !idxRise && !posWr) |=> st.pos == $past(st.pos) + 32'h1)
    else $error("pulse input not counted up");
  chk_index_zero: assert property (
    (idxRise && st.ctrl[`CTRL_IDX_ZERO] && !posWr) |=> st.pos == 32'h0)
    else $error("index did not zero position");
  chk_latch_capture: assert property (
    latchEv |=> (st.latch == $past(st.pos)) && !st.ctrl[`CTRL_LATCH_ARM])
    else $error("latch did not capture position");
  chk_compare_out: assert property (
    (st.pos == st.cmp) |=> cmpOut)
    else $error("compare output missed a match");
  chk_step_width: assert property (
    ($rose(stepOut) && stepper && !rst) |-> stepOut ##1 (stepOut || !stepper) ##1 !stepOut)
    else $error("step pulse width wrong");
  chk_servo_code: assert property (
    (!nx.ctrl[`CTRL_STEPPER]) |=> dacCode == st.dac)
    else $error("servo code not driven");
  chk_servo_quiet: assert property (
    !stepper |=> !stepOut)
    else $error("step pulse in servo mode");
  chk_reset_quad: assert property (@(posedge clk) disable iff (1'b0)
    rst |=> (st.ctrl == `CTRL_RESET) && !stepOut && !irq)
    else $error("reset did not select quadrature");
  chk_irq_level: assert property (
    irq == |(st.irqStat & st.irqMask))
    else $error("interrupt level mismatch");
  chk_pready_once: assert property (
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  cov_latch: cover property (latchEv);
  cov_compare: cover property ($rose(cmpOut));
  cov_step_done: cover property (irqSet[`IRQ_STEP]);
  cov_index: cover property (idxRise && st.ctrl[`CTRL_IDX_ZERO]);

endmodule // axis_encoder_step_interface

`default_nettype wire

// ### verif/axis_far_side.sv
// encoder and step amplifier standing at the far side of one axis
// assumes the bench calls the tasks; every change lands just after a clk edge
`timescale 1ns/1ns
`default_nettype none

module axis_far_side (
  input  wire logic clk,          // axis clock
  input  wire logic stepOut,      // step pulse from the axis
  input  wire logic dirOut,       // direction from the axis
  output logic      quadChannelA, // encoder a or pulse line
  output logic      quadChannelB, // encoder b or direction line
  output logic      encIndex      // index pulse
);
  logic [1:0] phase = 2'h0;
  logic       stepPrev = 1'b0;
  int         stepSum = 0;

  initial begin
    quadChannelA = 1'b0;
    quadChannelB = 1'b0;
    encIndex = 1'b0;
  end

  // every level stands three cycles, inside the decoder's rate limit
  task automatic hold(input logic a, input logic b);
    @(posedge clk);
    quadChannelA <= a;
    quadChannelB <= b;
    repeat (2) @(posedge clk);
  endtask

  // a leads b for positive n
  task automatic move(input int n);
    for (int i = 0; i < (n < 0 ? -n : n); i++) begin
      phase = n > 0 ? phase + 2'h1 : phase - 2'h1;
      hold(phase inside {2'h1, 2'h2}, phase[1]);
    end
  endtask

  task automatic pulses(input int n, input logic up);
    hold(1'b0, up);
    repeat (n) begin
      hold(1'b1, up);
      hold(1'b0, up);
    end
    phase = {phase[1], phase[1]};
    hold(1'b0, phase[1]);
  endtask

  task automatic indexPulse();
    @(posedge clk);
    encIndex <= 1'b1;
    repeat (3) @(posedge clk);
    encIndex <= 1'b0;
  endtask

  // amplifier: one signed step per rising edge of the step line
  always @(posedge clk) begin
    stepPrev <= stepOut;
    if (stepOut && !stepPrev)
      stepSum <= dirOut ? stepSum + 1 : stepSum - 1;
  end
endmodule // axis_far_side

`default_nettype wire

// ### verif/test_axis_encoder_step_interface.sv
// self-checking bench for one axis: apb registers, encoder counting, latch, compare, steps
// assumes the apb slave answers after one wait state and a 25 MHz clk
`timescale 1ns/1ns
`include "axis_consts.svh"
`default_nettype none

module test_axis_encoder_step_interface;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        genInput = 1'b0;
  logic [1:0]  auxLines = 2'h0;
  logic        pready, pslverr, cmpOut, stepOut, dirOut, irq, chA, chB, encIndex;
  logic [31:0] prdata;
  logic [15:0] dacCode;
  logic [32:0] expQ[$];
  logic [31:0] pos = 32'h0;
  logic [31:0] v;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;
  int          seed = 32'hf0e9;

  axis_encoder_step_interface i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .quadChannelA(chA), .quadChannelB(chB), .encIndex(encIndex),
    .genInput(genInput), .auxLines(auxLines), .cmpOut(cmpOut), .stepOut(stepOut),
    .dirOut(dirOut), .dacCode(dacCode), .irq(irq));
  axis_far_side i_far (.clk(clk), .stepOut(stepOut), .dirOut(dirOut), .quadChannelA(chA),
    .quadChannelB(chB), .encIndex(encIndex));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // read results are matched against the oldest note
  always @(posedge clk)
    if (psel && penable && pready && !pwrite)
      check({pslverr, prdata}, expQ.pop_front());

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    int n;
    int base;
    int sh;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(`ADDR_CTRL, 33'h0);
    check(33'({irq, dacCode}), 33'h0);
    n = 5 + ($random(seed) & 15);
    i_far.move(n);
    pos += 32'(n);
    rd(`ADDR_POS, {1'b0, pos});
    n = -(n + 3);
    i_far.move(n);
    pos += 32'(n);
    rd(`ADDR_POS, {1'b0, pos});
    wr(`ADDR_CTRL, 32'h2);
    for (int d = 0; d < 2; d++) begin
      i_far.pulses(3, d[0]);
      pos += d ? 32'h3 : -32'h3;
      rd(`ADDR_POS, {1'b0, pos});
    end
    wr(`ADDR_CTRL, 32'h0);
    wr(`ADDR_IRQ_STAT, 32'hf);
    wr(`ADDR_CMP, pos + 32'h2);
    wr(`ADDR_IRQ_MASK, 32'h2);
    i_far.move(1);
    repeat (5) @(posedge clk);
    check(33'({irq, cmpOut}), 33'h0);
    i_far.move(1);
    pos += 32'h2;
    repeat (5) @(posedge clk);
    check(33'({irq, cmpOut}), 33'h3);
    wr(`ADDR_IRQ_STAT, 32'h2);
    repeat (3) @(posedge clk);
    check(33'({irq, cmpOut}), 33'h1);
    wr(`ADDR_CTRL, 32'h20);
    i_far.move(3);
    pos += 32'h3;
    genInput <= 1'b1;
    repeat (3) @(posedge clk);
    genInput <= 1'b0;
    rd(`ADDR_LATCH, {1'b0, pos});
    rd(`ADDR_CTRL, 33'h0);
    rd(`ADDR_IRQ_STAT, 33'h1);
    check(33'(irq), 33'h0);
    wr(`ADDR_CTRL, 32'h30);
    i_far.move(-1);
    pos -= 32'h1;
    i_far.indexPulse();
    rd(`ADDR_LATCH, {1'b0, pos});
    rd(`ADDR_IRQ_STAT, 33'h5);
    wr(`ADDR_CTRL, 32'h40);
    i_far.indexPulse();
    rd(`ADDR_POS, 33'h0);
    wr(`ADDR_IRQ_STAT, 32'hf);
    v = 32'(($random(seed) & 3) | 1);
    auxLines <= v[1:0];
    rd(`ADDR_INPUTS, 33'h0);
    wr(`ADDR_CTRL, 32'h80);
    rd(`ADDR_INPUTS, 33'(v << 2));
    wr(`ADDR_CTRL, 32'h0);
    v = $random(seed);
    wr(`ADDR_DAC, v);
    rd(`ADDR_DAC, 33'(v[15:0]));
    check(33'(dacCode), 33'(v[15:0]));
    wr(`ADDR_STEP, 32'h1);
    repeat (10) @(posedge clk);
    check(33'(i_far.stepSum), 33'h0);
    for (int s = 0; s < 3; s++) begin
      n = ($random(seed) & 1) ? -(s + 1) : s + 1;
      sh = s == 0 ? 0 : s == 1 ? `SHIFT_HALF : `SHIFT_MICRO;
      base = i_far.stepSum;
      wr(`ADDR_CTRL, 32'(1 + (s << 2)));
      wr(`ADDR_STEP, 32'(n) & 32'hffff);
      repeat ((((n < 0) ? -n : n) << sh) * 4 + 10) @(posedge clk);
      check(33'(i_far.stepSum - base), 33'(n <<< sh));
      check(33'({dirOut, dacCode}), 33'(n > 0) << 16);
      rd(`ADDR_IRQ_STAT, 33'h8);
      wr(`ADDR_IRQ_STAT, 32'hf);
    end
    rd(8'h24, 33'h100000000);
    // mid-run reset with the encoder lines away from zero and stepper mode selected
    i_far.move(2);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`ADDR_CTRL, 33'h0);
    rd(`ADDR_POS, 33'h0);
    check(33'({irq, stepOut, dacCode}), 33'h0);
    complete_run();
  end
endmodule // test_axis_encoder_step_interface

`default_nettype wire
